// *** hw/tsc_top.sv ***
// timer input configuration, pin routing and three strobe counters on apb
`timescale 1ns/10ps
`include "tsc_map.svh"
module tsc_top
  import tsc_pkg::*;
#(
  parameter int NCNT = 3,
  parameter int W    = 16
)(
  input  wire logic            i_clock,
  input  wire logic            i_srst,
  input  wire logic            i_psel,
  input  wire logic            i_penable,
  input  wire logic            i_pwrite,
  input  wire logic [21:0]     i_paddr,
  input  wire logic [31:0]     i_pwdata,
  output logic      [31:0]     o_prdata,
  output logic                 o_pready,
  output logic                 o_pslverr,
  input  wire logic            i_prescaled_clock,
  input  wire logic [NCNT-1:0] i_external_timer_clock_pin,
  input  wire logic [NCNT-1:0] i_external_timer_gate_pin,
  output logic      [NCNT-1:0] o_counter_output,
  output logic      [1:0]      o_dma_request,
  output logic      [NCNT-1:0] o_external_timer_output_pin,
  output logic      [NCNT-1:0] o_external_timer_output_oe
);
  logic [7:0]          cfg_q;
  logic [7:0]          port3_cfg_q;
  logic [7:0]          periph_cfg_q;
  logic [W-1:0]        reload_q [NCNT];
  logic [NCNT-1:0]     ctrl_wr_q;
  logic [NCNT-1:0]     clk_s1_q, clk_s2_q, gate_s1_q, gate_s2_q;
  logic [NCNT-1:0]     clk_prev_q;
  logic [NCNT-1:0]     pulse;
  logic [NCNT-1:0]     gate;
  tsc_stat_s           stat [NCNT];
  logic                access;
  logic                wr;
  logic                hit;
  logic [31:0]         rdata;

  function automatic logic [21:0] byte_addr(input logic [19:0] i);
    byte_addr = {i, 2'b00};
  endfunction

  assign access = i_psel && i_penable;
  // write lands on the edge that samples pready high
  assign wr     = access && o_pready && i_pwrite && hit;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb
  begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    if (i_paddr[1:0] != 2'b00)
      hit = 1'b0;
    else if (i_paddr == byte_addr(`TSC_IDX_CFG))
      rdata = {24'h00_0000, cfg_q};
    else if (i_paddr == byte_addr(`TSC_IDX_PORT3))
      rdata = {24'h00_0000, port3_cfg_q};
    else if (i_paddr == byte_addr(`TSC_IDX_PERIPH))
      rdata = {24'h00_0000, periph_cfg_q};
    else if (i_paddr == byte_addr(`TSC_IDX_CTRL))
      rdata = 32'h0000_0000;
    else if (i_paddr == byte_addr(`TSC_IDX_STATUS))
      for (int k = 0; k < NCNT; k++)
      begin
        rdata[k]     = stat[k].out;
        rdata[8 + k] = stat[k].armed;
      end
    else
    begin
      hit = 1'b0;
      for (int k = 0; k < NCNT; k++)
        if (i_paddr == byte_addr(`TSC_IDX_COUNT0 + 20'(k)))
        begin
          hit   = 1'b1;
          rdata = 32'(reload_q[k]);
        end
    end
  end

  // one wait state keeps read data and pready straight from flops
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= access && !o_pready;
      o_prdata  <= rdata;
      o_pslverr <= access && !o_pready && !hit;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      cfg_q    <= `TSC_CFG_RESET;
      port3_cfg_q  <= `TSC_PIN_RESET;
      periph_cfg_q <= `TSC_PIN_RESET;
    end
    else if (wr && i_paddr == byte_addr(`TSC_IDX_CFG))
      cfg_q <= i_pwdata[7:0];
    else if (wr && i_paddr == byte_addr(`TSC_IDX_PORT3))
      port3_cfg_q <= i_pwdata[7:0];
    else if (wr && i_paddr == byte_addr(`TSC_IDX_PERIPH))
      periph_cfg_q <= i_pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // per counter: sync, source select, edge pulse, counter, routing
  for (genvar n = 0; n < NCNT; n++)
  begin : g_cnt
    logic clk_sel;

    always_ff @(posedge i_clock)
    begin
      if (i_srst)
        reload_q[n] <= W'(`TSC_CNT_RESET);
      else if (wr && i_paddr == byte_addr(`TSC_IDX_COUNT0 + 20'(n)))
        reload_q[n] <= i_pwdata[W-1:0];
    end

    always_ff @(posedge i_clock)
    begin
      if (i_srst)
        ctrl_wr_q[n] <= 1'b0;
      else
        ctrl_wr_q[n] <= wr && i_paddr == byte_addr(`TSC_IDX_CTRL)
                        && i_pwdata[n];
    end

    always_ff @(posedge i_clock)
    begin
      if (i_srst)
      begin
        clk_s1_q[n]  <= 1'b0;
        clk_s2_q[n]  <= 1'b0;
        gate_s1_q[n] <= 1'b0;
        gate_s2_q[n] <= 1'b0;
      end
      else
      begin
        clk_s1_q[n]  <= i_external_timer_clock_pin[n];
        clk_s2_q[n]  <= clk_s1_q[n];
        gate_s1_q[n] <= i_external_timer_gate_pin[n];
        gate_s2_q[n] <= gate_s1_q[n];
      end
    end

    // prescaled clock is already in this domain
    assign clk_sel = cfg_q[2*n] ? clk_s2_q[n] : i_prescaled_clock;

    always_ff @(posedge i_clock)
    begin
      if (i_srst)
        clk_prev_q[n] <= 1'b0;
      else
        clk_prev_q[n] <= clk_sel;
    end

    assign pulse[n] = clk_sel && !clk_prev_q[n]
                      && !cfg_q[`TSC_BIT_DISABLE];

    always_comb
    begin
      if (cfg_q[`TSC_BIT_SWGATE])
        gate[n] = cfg_q[2*n+1];
      else
        gate[n] = cfg_q[2*n+1] ? gate_s2_q[n] : 1'b1;
    end

    tsc_counter #(.W(W)) u_counter (
      .i_clock         (i_clock),
      .i_srst          (i_srst),
      .i_pulse         (pulse[n]),
      .i_gate          (gate[n]),
      .i_control_write (ctrl_wr_q[n]),
      .i_reload        (reload_q[n]),
      .o_stat          (stat[n])
    );

    always_ff @(posedge i_clock)
    begin
      if (i_srst)
      begin
        o_counter_output[n]            <= 1'b1;
        o_external_timer_output_pin[n] <= 1'b1;
        o_external_timer_output_oe[n]  <= 1'b0;
      end
      else
      begin
        o_counter_output[n]            <= stat[n].out;
        o_external_timer_output_pin[n] <= stat[n].out;
        o_external_timer_output_oe[n]  <= (n == 2)
          ? periph_cfg_q[`TSC_BIT_CNT2PIN] : port3_cfg_q[n];
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_dma_request <= 2'b11;
    else
      o_dma_request <= {stat[2].out, stat[1].out};
  end

  ////////////////////////////////////////////////////////////////////////////
  a_disable_blocks: assert property (@(posedge i_clock) disable iff (i_srst)
    cfg_q[`TSC_BIT_DISABLE] |-> pulse == '0)
    else $error("counter clock passed while disabled");
  a_dma_follows: assert property (@(posedge i_clock) disable iff (i_srst)
    ##1 o_dma_request == $past({stat[2].out, stat[1].out}))
    else $error("dma request does not follow counters");
  a_pin_gate: assert property (@(posedge i_clock) disable iff (i_srst)
    !port3_cfg_q[0] |=> !o_external_timer_output_oe[0])
    else $error("counter 0 pin driven while not selected");
  a_cfg_reset: assert property (@(posedge i_clock)
    $fell(i_srst) |-> cfg_q == 8'h00)
    else $error("configuration not zero after reset");
  a_sw_gate: assert property (@(posedge i_clock) disable iff (i_srst)
    cfg_q[`TSC_BIT_SWGATE] |-> gate[0] == cfg_q[1])
    else $error("software gate level not applied");
  c_pin_on: cover property (@(posedge i_clock) o_external_timer_output_oe[0]);
  c_ext_clock: cover property (@(posedge i_clock) pulse[1] && cfg_q[2]);
endmodule

// *** hw/tsc_map.svh ***
// register map, field positions and reset values of the timer input block
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH
// printed offsets are register indices; byte address is four times these
`define TSC_IDX_CFG      20'hf834
`define TSC_IDX_PORT3    20'hf824
`define TSC_IDX_PERIPH   20'hf826
`define TSC_IDX_COUNT0   20'hf840
`define TSC_IDX_CTRL     20'hf843
`define TSC_IDX_STATUS   20'hf844
`define TSC_CFG_RESET    8'h00
`define TSC_PIN_RESET    8'h00
`define TSC_BIT_DISABLE  7
`define TSC_BIT_SWGATE   6
`define TSC_BIT_CNT2PIN  5
`define TSC_CNT_RESET    16'h0000
`endif

// *** hw/tsc_pkg.sv ***
// types shared by the timer input block
package tsc_pkg;
  typedef enum logic [1:0] {
    TSC_IDLE = 2'b00,
    TSC_LOAD = 2'b01,
    TSC_RUN  = 2'b10
  } tsc_state_e;
  typedef struct packed {
    logic out;
    logic armed;
  } tsc_stat_s;
endpackage

// *** hw/tsc_counter.sv ***
// one counter in hardware-triggered strobe mode
`timescale 1ns/10ps
`include "tsc_map.svh"
module tsc_counter
  import tsc_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic         i_clock,
  input  wire logic         i_srst,
  input  wire logic         i_pulse,
  input  wire logic         i_gate,
  input  wire logic         i_control_write,
  input  wire logic [W-1:0] i_reload,
  output tsc_stat_s         o_stat
);
  tsc_state_e     state_q;
  logic [W-1:0]   count_q;
  logic [W-1:0]   count_dec;
  logic           gate_prev_q;
  logic           out_q;
  logic           armed_q;
  logic           trigger;

  assign count_dec = count_q - {{(W-1){1'b0}}, 1'b1};
  // gate sampled only on counter clock pulses
  assign trigger = i_pulse && i_gate && !gate_prev_q;
  assign o_stat = '{out: out_q, armed: armed_q};

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      gate_prev_q <= 1'b1;
    else if (i_pulse)
      gate_prev_q <= i_gate;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      state_q <= TSC_IDLE;
      count_q <= W'(`TSC_CNT_RESET);
      out_q   <= 1'b1;
      armed_q <= 1'b0;
    end
    else if (i_control_write)
    begin
      state_q <= TSC_IDLE;
      out_q   <= 1'b1;
      armed_q <= 1'b0;
    end
    else if (i_pulse)
    begin
      case (state_q)
        TSC_IDLE:
        begin
          out_q <= 1'b1;
          if (trigger)
            state_q <= TSC_LOAD;
        end
        TSC_LOAD:
        begin
          // reload value is only taken here, after a trigger
          count_q <= i_reload;
          out_q   <= (i_reload != '0);
          armed_q <= (i_reload != '0);
          state_q <= trigger ? TSC_LOAD : TSC_RUN;
        end
        TSC_RUN:
        begin
          count_q <= count_dec;
          out_q   <= !(armed_q && count_dec == '0);
          if (count_dec == '0)
            armed_q <= 1'b0;
          if (trigger)
            state_q <= TSC_LOAD;
        end
        default:
          state_q <= TSC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_low_one_pulse: assert property (@(posedge i_clock) disable iff (i_srst)
    $fell(out_q) |=> !out_q until_with i_pulse || i_control_write)
    else $error("strobe ended before the next pulse");
  a_load_after_trig: assert property (@(posedge i_clock) disable iff (i_srst)
    trigger && !i_control_write |=> state_q == TSC_LOAD)
    else $error("trigger did not schedule a load");
  a_ctrl_drives_high: assert property (@(posedge i_clock)
    disable iff (i_srst) i_control_write |=> out_q && !armed_q)
    else $error("control write left output low");
  a_count_held: assert property (@(posedge i_clock) disable iff (i_srst)
    !i_pulse && !i_control_write |=> $stable(count_q))
    else $error("count moved without a pulse");
  a_single_strobe: assert property (@(posedge i_clock) disable iff (i_srst)
    i_pulse && state_q == TSC_RUN && !armed_q |=> out_q)
    else $error("strobe repeated without a reload");
  c_strobe: cover property (@(posedge i_clock) $fell(out_q));
  c_retrigger: cover property (@(posedge i_clock)
    trigger && state_q == TSC_RUN && armed_q);
endmodule

// *** verif/tsc_ext_src.sv ***
// external clock and gate pin sources for the timer bench
`timescale 1ns/10ps
module tsc_ext_src #(
  parameter int NCNT = 3
)(
  output logic [NCNT-1:0] o_clock_pin,
  output logic [NCNT-1:0] o_gate_pin
);
  // clock pins rest low between pulses; the bench sets the pulse width
  initial
  begin
    o_clock_pin = '0;
    o_gate_pin  = '0;
  end
  task automatic drive(input logic [NCNT-1:0] clk_m,
                       input logic [NCNT-1:0] gate_m);
    o_clock_pin <= clk_m;
    o_gate_pin  <= gate_m;
  endtask
endmodule

// *** verif/tb_top.sv ***
// self-checking bench for the timer input block
`timescale 1ns/10ps
`include "tsc_map.svh"
module tb_top;
  localparam logic [21:0] A_CFG = {`TSC_IDX_CFG, 2'b00};
  localparam logic [21:0] A_P3  = {`TSC_IDX_PORT3, 2'b00};
  localparam logic [21:0] A_PIN = {`TSC_IDX_PERIPH, 2'b00};
  localparam logic [21:0] A_CNT = {`TSC_IDX_COUNT0, 2'b00};
  localparam logic [21:0] A_CTL = {`TSC_IDX_CTRL, 2'b00};
  localparam logic [21:0] A_ST  = {`TSC_IDX_STATUS, 2'b00};
  localparam logic [21:0] A_BAD = {20'hf830, 2'b00};
  logic        clk;
  logic        srst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic        pready;
  logic        pslverr;
  logic        pre_clk;
  logic        er;
  logic [21:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [2:0]  eclk;
  logic [2:0]  egate;
  logic [2:0]  cout;
  logic [2:0]  pin;
  logic [2:0]  oe;
  logic [1:0]  dma;
  logic [7:0]  cfg;
  logic [7:0]  p3;
  logic [7:0]  pcf;
  logic [15:0] rel [3];
  integer      seed;
  integer      bad_count;
  integer      total_checks;
  integer      cycles;
  integer      i;
  integer      j;
  integer      r;
  int          cnt [3];
  bit          outm [3];
  bit          arm [3];
  bit          ld [3];
  bit          gp [3];

  tsc_top #(.NCNT(3), .W(16)) tsc_top_inst (
    .i_clock(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_prescaled_clock(pre_clk),
    .i_external_timer_clock_pin(eclk), .i_external_timer_gate_pin(egate),
    .o_counter_output(cout), .o_dma_request(dma),
    .o_external_timer_output_pin(pin), .o_external_timer_output_oe(oe));
  tsc_ext_src #(.NCNT(3)) tsc_ext_src_inst (
    .o_clock_pin(eclk), .o_gate_pin(egate));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk_reg(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task chk_pin(input logic [10:0] g, input logic [10:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task chk_outs;
    logic [2:0] ov;
    ov = {outm[2], outm[1], outm[0]};
    chk_pin({cout, dma, pin, oe},
            {ov, ov[2:1], ov, pcf[5], p3[1:0]});
  endtask

  // no fixed answer time assumed: the global timeout ends a hang
  task apb(input logic w, input logic [21:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task tick(input logic ps, input logic [2:0] m, input int hi);
    logic g;
    @(posedge clk);
    pre_clk <= ps;
    tsc_ext_src_inst.drive(m, egate);
    repeat (hi) @(posedge clk);
    pre_clk <= 1'b0;
    tsc_ext_src_inst.drive(3'b000, egate);
    for (int n = 0; n < 3; n++)
      if (!cfg[7] && (cfg[2*n] ? m[n] : ps))
      begin
        g = cfg[6] ? cfg[2*n+1] : (!cfg[2*n+1] || egate[n]);
        outm[n] = 1;
        if (ld[n])
        begin
          cnt[n] = rel[n];
          arm[n] = 1;
          ld[n] = 0;
        end
        else
          cnt[n] = (cnt[n] + 65535) % 65536;
        if (cnt[n] == 0 && arm[n])
        begin
          outm[n] = 0;
          arm[n] = 0;
        end
        if (g && !gp[n])
          ld[n] = 1;
        gp[n] = g;
      end
    // synchroniser, edge detect and output lag settle well inside this
    repeat (8) @(posedge clk);
    chk_outs();
  endtask
////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  initial
  begin
    seed = 41;
    bad_count = 0;
    total_checks = 0;
    cycles = 0;
    srst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = '0;
    pwdata = '0;
    pre_clk = 1'b0;
    cfg = 8'h00;
    p3 = 8'h00;
    pcf = 8'h00;
    for (i = 0; i < 3; i++)
    begin
      cnt[i] = 0;
      outm[i] = 1;
      arm[i] = 0;
      ld[i] = 0;
      gp[i] = 1;
      rel[i] = 16'h0000;
    end
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    chk_outs();
    apb(1'b0, A_CFG, 32'h0);
    chk_reg(rd, 32'h0);
    apb(1'b0, A_BAD, 32'h0);
    chk_reg({rd[30:0], er}, 32'h1);
    apb(1'b1, A_CFG + 22'h1, 32'hff);
    apb(1'b0, A_CFG, 32'h0);
    chk_reg(rd, 32'h0);
    for (i = 0; i < 400; i++)
    begin
      r = $random(seed);
      case (r[3:0])
        0:
        begin
          cfg = r[11:4] & ((r[13:12] == 2'b00) ? 8'hff : 8'h7f);
          apb(1'b1, A_CFG, {24'h0, cfg});
          apb(1'b0, A_CFG, 32'h0);
          chk_reg(rd, {24'h0, cfg});
        end
        1:
        begin
          j = r[5:4] % 3;
          rel[j] = {13'h0, r[8:6]};
          apb(1'b1, A_CNT + 22'(4 * j), {16'h0, rel[j]});
          apb(1'b0, A_CNT + 22'(4 * j), 32'h0);
          chk_reg(rd, {16'h0, rel[j]});
        end
        2:
        begin
          apb(1'b1, A_CTL, {29'h0, r[6:4]});
          for (j = 0; j < 3; j++)
            if (r[4+j])
            begin
              outm[j] = 1;
              arm[j] = 0;
              ld[j] = 0;
            end
          apb(1'b0, A_CTL, 32'h0);
          chk_reg(rd, 32'h0);
          chk_outs();
        end
        3:
        begin
          tsc_ext_src_inst.drive(3'b000, r[6:4]);
          repeat (4) @(posedge clk);
        end
        4:
        begin
          p3 = r[11:4];
          pcf = r[19:12];
          apb(1'b1, A_P3, {24'h0, p3});
          apb(1'b1, A_PIN, {24'h0, pcf});
          apb(1'b0, A_ST, 32'h0);
          chk_reg(rd & 32'h7, {29'h0, outm[2], outm[1], outm[0]});
          chk_outs();
        end
        default: tick(r[4], r[7:5], 1 + r[9:8]);
      endcase
    end
    end_of_test();
  end
endmodule
